// ==== rtl/tap_pkg.sv ====
/*
  Constants, codes and state type for the boundary-scan test port.
  Assumes nothing of its surroundings; shared by all test-port files.
*/
package tap_pkg;

  // widths of the scan registers
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BS_W = 107;

  // instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
  localparam logic [IR_W-1:0] INS_PRELOAD = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

  // fixed pattern loaded on instruction capture (low two bits 01)
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  // instruction after reset
  localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

  // identification fields; part and maker codes are arbitrary values
  localparam logic [2:0] ID_REVISION = 3'h0;
  localparam logic [16:0] ID_PART = 17'h0ABCD;
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic ID_PRESENT = 1'h1;
  localparam logic [ID_W-1:0] ID_VALUE =
    {ID_REVISION, ID_PART, ID_MAKER, ID_PRESENT};

  // boundary cell that gates the output bus under external test
  localparam int BS_TRISTATE_BIT = 47;
  // update latch after reset: output-enable cell preset high
  localparam logic [BS_W-1:0] BS_UPDATE_RESET = {{(BS_W-48){1'b0}},
    1'b1, {47{1'b0}}};

  // reset values of single-bit state
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic OUT_EN_RESET = 1'h1;
  localparam logic TDO_RESET = 1'h0;
  localparam logic TDO_EN_RESET = 1'h0;

  // test-port controller states
  typedef enum logic [3:0] {
    S_RESET, S_IDLE,
    S_SEL_DR, S_CAP_DR, S_SHIFT_DR, S_EXIT1_DR, S_PAUSE_DR,
    S_EXIT2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SHIFT_IR, S_EXIT1_IR, S_PAUSE_IR,
    S_EXIT2_IR, S_UPD_IR
  } tap_state_t;

endpackage

// ==== rtl/tap_fsm.sv ====
/*
  Sixteen-state test-port controller, stepped by mode-select.
  Assumes mode-select is stable around each rising test-clock edge.
*/
`timescale 1ns/100ps
module tap_fsm
  import tap_pkg::*;
(
  // test clock and power-up reset
  input wire logic tck,
  input wire logic rstn,
  // mode select
  input wire logic tms,
  // current controller state
  output tap_state_t state
);

  tap_state_t state_reg; // present state
  tap_state_t state_next; // state after the next rising edge

  // next state from mode-select; five highs reach reset from anywhere
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_RESET: state_next = tms ? S_RESET : S_IDLE;
      S_IDLE: state_next = tms ? S_SEL_DR : S_IDLE;
      S_SEL_DR: state_next = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_next = tms ? S_EXIT1_DR : S_SHIFT_DR;
      S_SHIFT_DR: state_next = tms ? S_EXIT1_DR : S_SHIFT_DR;
      S_EXIT1_DR: state_next = tms ? S_UPD_DR : S_PAUSE_DR;
      S_PAUSE_DR: state_next = tms ? S_EXIT2_DR : S_PAUSE_DR;
      S_EXIT2_DR: state_next = tms ? S_UPD_DR : S_SHIFT_DR;
      S_UPD_DR: state_next = tms ? S_SEL_DR : S_IDLE;
      S_SEL_IR: state_next = tms ? S_RESET : S_CAP_IR;
      S_CAP_IR: state_next = tms ? S_EXIT1_IR : S_SHIFT_IR;
      S_SHIFT_IR: state_next = tms ? S_EXIT1_IR : S_SHIFT_IR;
      S_EXIT1_IR: state_next = tms ? S_UPD_IR : S_PAUSE_IR;
      S_PAUSE_IR: state_next = tms ? S_EXIT2_IR : S_PAUSE_IR;
      S_EXIT2_IR: state_next = tms ? S_UPD_IR : S_SHIFT_IR;
      S_UPD_IR: state_next = tms ? S_SEL_DR : S_IDLE;
      default: state_next = S_RESET;
    endcase
  end

  // mode-select sampled on the rising test-clock edge
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;

  // five consecutive highs always land in reset
  a_five_high_reset: assert property (
    @(posedge tck) disable iff (!rstn)
    tms [*5] |=> state_reg == S_RESET)
    else $error("five mode-select highs did not reset the port");

  // a low in reset moves to idle
  a_reset_to_idle: assert property (
    @(posedge tck) disable iff (!rstn)
    (state_reg == S_RESET && !tms) |=> state_reg == S_IDLE)
    else $error("reset with mode-select low did not go idle");

endmodule

// ==== rtl/sram_boundary_scan_tap.sv ====
/*
  Boundary-scan test port of the memory: instruction register,
  bypass, identification and 107-bit boundary registers, serial out.
  Assumes an external scan controller drives tck, tms and tdi, that the
  pin ring arrives on ringIn, and that the memory output drivers obey
  memOutEnable, which lives in the memory clock domain.
*/
`timescale 1ns/100ps
module sram_boundary_scan_tap
  import tap_pkg::*;
(
  // memory clock domain
  input wire logic clock,
  input wire logic rstn,
  // serial test link, on its own clock
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  // pin ring seen by the boundary register
  input wire logic [BS_W-1:0] ringIn,
  // output driver enable toward the memory, memory clock domain
  output logic memOutEnable
);

// Behaviour
// - mode-select sampled on rising edge steps state
// - code 000 captures pin ring into boundary
// - code 001 captures and shifts identity word
// - code 010 captures ring, outputs high impedance
// - code 100 captures ring, memory unaffected
// - code 111 selects single-bit bypass
// - boundary instructions shift through 107 bits
// - identity: revision, part, maker, presence fields
// - identity bit zero always reads one
// - part field holds fixed organisation code
// - five mode-select highs reset the port
// - sample tdi rising, change tdo falling
// - reset loads identity instruction
// - instruction capture loads pattern 01

  tap_state_t state; // controller state from the step machine

  // instruction path
  logic [IR_W-1:0] irShift_reg; // instruction shift stage
  logic [IR_W-1:0] ir_reg; // active instruction
  // data registers
  logic bypass_reg; // single-bit bypass
  logic [ID_W-1:0] idShift_reg; // identification shift stage
  logic [BS_W-1:0] bsShift_reg; // boundary shift stage
  logic [BS_W-1:0] bsUpdate_reg; // boundary update latch
  // pin ring synchroniser into the test clock domain
  logic [BS_W-1:0] ringMeta_reg; // first stage, read by second only
  logic [BS_W-1:0] ringSync_reg; // second stage, safe to use
  // serial output, falling edge
  logic tdo_reg;
  logic tdoEn_reg;
  // output enable level, then its crossing to the memory clock
  logic outEnTck_reg;
  logic outEnMeta_reg; // first stage, read by second only
  logic outEnSync_reg;

  // boundary register selected for the data path
  function automatic logic isBoundary(input logic [IR_W-1:0] code);
    return (code == INS_EXTEST) || (code == INS_SAMPLEZ) ||
      (code == INS_PRELOAD);
  endfunction

  // identification register selected for the data path
  function automatic logic isIdent(input logic [IR_W-1:0] code);
    return code == INS_IDCODE;
  endfunction

  // named decodes of the active instruction
  wire logic selBoundary = isBoundary(ir_reg);
  wire logic selIdent = isIdent(ir_reg);
  // anything else, reserved codes included, uses bypass
  wire logic selBypass = !selBoundary && !selIdent;

  // state decodes
  wire logic inCapDr = (state == S_CAP_DR);
  wire logic inShiftDr = (state == S_SHIFT_DR);
  wire logic inUpdDr = (state == S_UPD_DR);
  wire logic inCapIr = (state == S_CAP_IR);
  wire logic inShiftIr = (state == S_SHIFT_IR);
  wire logic inUpdIr = (state == S_UPD_IR);
  wire logic inReset = (state == S_RESET);

  // serial bit presented at tdo while shifting
  wire logic drOut = selBoundary ? bsShift_reg[0] :
    (selIdent ? idShift_reg[0] : bypass_reg);
  wire logic serialOut = inShiftIr ? irShift_reg[0] : drOut;
  wire logic shifting = inShiftIr || inShiftDr;

  // output drivers: off under sample-z, or under external test when
  // the latched tristate cell is low
  wire logic outEnNext = !(ir_reg == INS_SAMPLEZ) &&
    !((ir_reg == INS_EXTEST) && !bsUpdate_reg[BS_TRISTATE_BIT]);

  // controller stepping
  tap_fsm fsm (
    .tck(tck),
    .rstn(rstn),
    .tms(tms),
    .state(state)
  );

  // pin ring passes two flops; capture may still see a moving pin,
  // which the part tolerates but cannot promise a value for
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      ringMeta_reg <= '0;
      ringSync_reg <= '0;
    end else begin
      ringMeta_reg <= ringIn;
      ringSync_reg <= ringMeta_reg;
    end
  end

  // instruction shift stage: capture pattern, then shift lsb first
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      irShift_reg <= IR_RESET;
    end else if (inCapIr) begin
      irShift_reg <= IR_CAPTURE;
    end else if (inShiftIr) begin
      irShift_reg <= {tdi, irShift_reg[IR_W-1:1]};
    end
  end

  // active instruction: identity after power-up and in reset
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      ir_reg <= IR_RESET;
    end else if (inReset) begin
      ir_reg <= IR_RESET;
    end else if (inUpdIr) begin
      ir_reg <= irShift_reg;
    end
  end

  // bypass cell: captures low, then passes tdi with one bit of delay
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      bypass_reg <= BYPASS_CAPTURE;
    end else if (inCapDr && selBypass) begin
      bypass_reg <= BYPASS_CAPTURE;
    end else if (inShiftDr && selBypass) begin
      bypass_reg <= tdi;
    end
  end

  // identification word: fixed value captured, shifted lsb first
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      idShift_reg <= ID_VALUE;
    end else if (inCapDr && selIdent) begin
      idShift_reg <= ID_VALUE;
    end else if (inShiftDr && selIdent) begin
      idShift_reg <= {tdi, idShift_reg[ID_W-1:1]};
    end
  end

  // boundary shift stage: tdi enters at the msb, lsb feeds tdo
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      bsShift_reg <= '0;
    end else if (inCapDr && selBoundary) begin
      bsShift_reg <= ringSync_reg;
    end else if (inShiftDr && selBoundary) begin
      bsShift_reg <= {tdi, bsShift_reg[BS_W-1:1]};
    end
  end

  // update latch; reset presets the output-enable cell high
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      bsUpdate_reg <= BS_UPDATE_RESET;
    end else if (inReset) begin
      bsUpdate_reg <= BS_UPDATE_RESET;
    end else if (inUpdDr && selBoundary) begin
      bsUpdate_reg <= bsShift_reg;
    end
  end

  // output-enable level registered before it leaves this domain
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      outEnTck_reg <= OUT_EN_RESET;
    end else begin
      outEnTck_reg <= outEnNext;
    end
  end

  // serial output changes on the falling edge, half a cycle of margin
  always_ff @(negedge tck or negedge rstn) begin
    if (!rstn) begin
      tdo_reg <= TDO_RESET;
      tdoEn_reg <= TDO_EN_RESET;
    end else begin
      tdo_reg <= serialOut;
      tdoEn_reg <= shifting;
    end
  end

  // level crossing into the memory clock; a few cycles of lag only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outEnMeta_reg <= OUT_EN_RESET;
      outEnSync_reg <= OUT_EN_RESET;
    end else begin
      outEnMeta_reg <= outEnTck_reg;
      outEnSync_reg <= outEnMeta_reg;
    end
  end

  assign tdo = tdo_reg;
  assign tdoEn = tdoEn_reg;
  assign memOutEnable = outEnSync_reg;

  a_ir_reset_ident: assert property (
    @(posedge tck) disable iff (!rstn)
    inReset |=> ir_reg == INS_IDCODE)
    else $error("reset did not restore identity instruction");

  a_ir_capture_pat: assert property (
    @(posedge tck) disable iff (!rstn)
    inCapIr |=> irShift_reg[1:0] == 2'b01)
    else $error("instruction capture pattern wrong");

  a_ident_capture: assert property (
    @(posedge tck) disable iff (!rstn)
    (inCapDr && ir_reg == INS_IDCODE) |=>
      (idShift_reg == ID_VALUE && idShift_reg[0]))
    else $error("identity word not captured");

  a_bypass_path: assert property (
    @(posedge tck) disable iff (!rstn)
    (inShiftDr && ir_reg == INS_BYPASS) |=> bypass_reg == $past(tdi))
    else $error("bypass cell did not follow tdi");

  a_bypass_capture: assert property (
    @(posedge tck) disable iff (!rstn)
    (inCapDr && ir_reg == INS_BYPASS) |=> !bypass_reg)
    else $error("bypass cell did not capture low");

  a_ring_capture: assert property (
    @(posedge tck) disable iff (!rstn)
    (inCapDr && (ir_reg == INS_EXTEST || ir_reg == INS_PRELOAD))
      |=> bsShift_reg == $past(ringSync_reg))
    else $error("boundary register missed the pin ring");

  a_boundary_shift: assert property (
    @(posedge tck) disable iff (!rstn)
    (inShiftDr && selBoundary) |=>
      (bsShift_reg[BS_W-1] == $past(tdi) &&
       bsShift_reg[BS_W-2:0] == $past(bsShift_reg[BS_W-1:1])))
    else $error("boundary register did not shift");

  a_samplez_off: assert property (
    @(posedge tck) disable iff (!rstn)
    (ir_reg == INS_SAMPLEZ) [*2] |-> !outEnTck_reg)
    else $error("outputs still enabled under sample-z");

  a_preload_on: assert property (
    @(posedge tck) disable iff (!rstn)
    (ir_reg == INS_PRELOAD) [*2] |-> outEnTck_reg)
    else $error("sample-preload disturbed the outputs");

endmodule

// ==== test/scan_master.sv ====
/*
  Behavioural scan controller that drives the test link.
  Assumes the bench calls one task at a time; tck rests low between.
*/
`timescale 1ns/100ps
module scan_master (
  // link toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  // serial answer and its pad enable
  input wire logic tdo,
  input wire logic tdoEn
);
  logic lastTdo = 1'b0; // last level seen while the pad drove
  // a released pad shows no stale bit, so invert the last one
  wire tdoLine = tdoEn ? tdo : ~lastTdo;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // remember the driven level
  always @(posedge tck) begin
    if (tdoEn) lastTdo <= tdo;
  end

  // one link cycle; odd split keeps rising edges off the memory clock edges, falling edges land on them
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #31.7;
    q = tdoLine;
    tck = 1'b1;
    #32.3;
    tck = 0;
  endtask

  // from idle: select, capture, shift n bits lsb first, update, idle
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // only defined codes are ever loaded
  task automatic load_ir(input logic [2:0] code);
    logic [127:0] x;
    scan(1'b1, 3, {125'h0, code}, x);
  endtask

  // five rising edges with mode-select high, then back to idle
  task automatic tap_reset;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// ==== test/testbench.sv ====
/*
  Self-checking bench for the boundary-scan test port.
  Assumes scan_master plays the external scan controller.
*/
`timescale 1ns/100ps
module testbench;
  import tap_pkg::*;
  logic clock;
  logic rstn;
  logic [BS_W-1:0] ringIn;
  logic [BS_W-1:0] pat = {3'h5, {13{8'hC3}}}; // ring pattern
  // preload data: every cell high except the bus-gating cell
  logic [127:0] pre = {21'h0, {59{1'b1}}, 1'b0, {47{1'b1}}};
  logic [127:0] got;
  logic q;
  wire tck, tms, tdi, tdo, tdoEn, memOutEnable;
  int n_errors = 0;
  int tests_run = 0;

  sram_boundary_scan_tap dut (.clock(clock), .rstn(rstn), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .ringIn(ringIn),
    .memOutEnable(memOutEnable));
  scan_master ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn));

  // memory clock, 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string what, input logic [127:0] exp,
                     input logic [127:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // enable is registered on the tck edge after the instruction lands,
  // so give one idle tck step, then wait out the two-flop sync
  task automatic settle;
    ctl.step(1'b0, 1'b0, q);
    repeat (4) @(negedge clock);
  endtask

  task automatic t_ident;
    ctl.scan(1'b1, 3, {125'h0, INS_IDCODE}, got);
    chk("ir capture", IR_CAPTURE[1:0], got[1:0]);
    ctl.scan(1'b0, 32, '0, got);
    chk("id word", {ID_REVISION, ID_PART, ID_MAKER, 1'b1}, got);
    chk("id part", ID_PART, got[28:12]);
    chk("id present", 1'b1, got[0]);
    $display("test ident done");
  endtask

  task automatic t_bypass;
    ctl.load_ir(INS_BYPASS);
    ctl.scan(1'b0, 8, 128'hA5, got);
    chk("bypass delay", 8'h4A, got[7:0]);
    settle();
    chk("bypass bus", 1'b1, memOutEnable);
    $display("test bypass done");
  endtask

  task automatic t_preload_extest;
    @(negedge clock);
    ringIn = pat;
    ctl.load_ir(INS_PRELOAD);
    ctl.scan(1'b0, BS_W, pre, got);
    chk("preload capture", pat, got[BS_W-1:0]);
    settle();
    chk("preload bus", 1'b1, memOutEnable);
    @(negedge clock);
    ringIn = ~pat;
    ctl.load_ir(INS_EXTEST);
    settle();
    chk("extest bus off", 1'b0, memOutEnable);
    ctl.scan(1'b0, BS_W, pre, got);
    chk("extest capture", {~pat}, got[BS_W-1:0]);
    ctl.tap_reset();
    settle();
    chk("reset bus on", 1'b1, memOutEnable);
    ctl.scan(1'b0, 32, '0, got);
    chk("reset id", ID_VALUE, got);
    $display("test preload extest done");
  endtask

  task automatic t_samplez;
    @(negedge clock);
    ringIn = pat;
    ctl.load_ir(INS_SAMPLEZ);
    settle();
    chk("samplez bus off", 1'b0, memOutEnable);
    ctl.scan(1'b0, BS_W, '0, got);
    chk("samplez capture", pat, got[BS_W-1:0]);
    ctl.load_ir(INS_BYPASS);
    settle();
    chk("bus back on", 1'b1, memOutEnable);
    $display("test samplez done");
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    ringIn = '0;
    repeat (2) @(negedge clock);
    chk("reset tdo", 1'b0, tdo);
    chk("reset pad", 1'b0, tdoEn);
    chk("reset bus", 1'b1, memOutEnable);
    rstn = 1'b1;
    @(negedge clock);
    ctl.step(1'b0, 1'b0, q);
    t_ident();
    t_bypass();
    t_preload_extest();
    t_samplez();
    report_and_stop();
  end

  // watchdog, several times the expected run
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule
